//--- bsf_pkg.sv
// Shared constants and carrier types for the bit-serial table filter
package bsf_pkg;

  localparam int DATA_W_DEF    = 8;   // Input sample width
  localparam int TAPS_DEF      = 16;  // Filter length
  localparam int SECTION_TAPS  = 8;   // Taps served by one table section
  localparam int PAIRS_PER_SEC = 4;   // Tap pairs addressing one table
  localparam int OUT_W_DEF     = 19;  // Full-precision output width
  localparam int COEF_W_DEF    = 8;   // Coefficient width
  localparam int DECIM_DEF     = 1;   // Decimation factor
  localparam int PAR_DEF       = 1;   // Computational chains (1 or 2)
  localparam int ACC_SHIFT_1   = 1;   // Accumulator shift, serial form
  localparam int ACC_SHIFT_2   = 2;   // Accumulator shift, two-chain form

  typedef enum logic [1:0] {
    BSF_IDLE,
    BSF_RUN,
    BSF_DONE
  } bsf_state_type;

  typedef struct packed {
    logic       first;    // Clears accumulator
    logic       add_sub;  // 1 add, 0 subtract sign slice
    logic       last;     // Final slice of this computation
  } bsf_ctrl_type;

endpackage : bsf_pkg

//--- bsf_coef_table.sv
`timescale 1ns/1ps
// Precomputed partial-product table for one 8-tap section
module bsf_coef_table
  import bsf_pkg::*;
#(
  parameter int                 COEF_W = COEF_W_DEF,
  parameter logic signed [31:0] H0     = 32'sd1,
  parameter logic signed [31:0] H1     = 32'sd2,
  parameter logic signed [31:0] H2     = 32'sd3,
  parameter logic signed [31:0] H3     = 32'sd4
) (
  input  wire logic [3:0]          addr_in,
  output logic signed [COEF_W+1:0] sum_out
);

  logic signed [COEF_W+1:0] h0;
  logic signed [COEF_W+1:0] h1;
  logic signed [COEF_W+1:0] h2;
  logic signed [COEF_W+1:0] h3;

  assign h0 = H0[COEF_W+1:0];
  assign h1 = H1[COEF_W+1:0];
  assign h2 = H2[COEF_W+1:0];
  assign h3 = H3[COEF_W+1:0];

  // Folded into constants by synthesis since all coefficients are fixed
  always_comb begin
    sum_out = '0;
    if (addr_in[0]) sum_out = sum_out + h0;
    if (addr_in[1]) sum_out = sum_out + h1;
    if (addr_in[2]) sum_out = sum_out + h2;
    if (addr_in[3]) sum_out = sum_out + h3;
  end

endmodule : bsf_coef_table

//--- bsf_slice_ctrl.sv
`timescale 1ns/1ps
// Bit-slice sequencer: accepts samples and steers add/subtract
module bsf_slice_ctrl
  import bsf_pkg::*;
#(
  parameter int SLICES = DATA_W_DEF + 1,
  parameter int DECIM  = DECIM_DEF
) (
  input  wire logic   sys_clk_in,
  input  wire logic   rst_in,
  input  wire logic   clk_en_in,
  input  wire logic   sample_valid_in,
  output logic        sample_take_out,
  output logic        load_out,
  output bsf_ctrl_type ctrl_out,
  output logic        result_keep_out
);

  localparam int CW = $clog2(SLICES + 1);
  localparam int DW = $clog2(DECIM + 1);

  bsf_state_type state_q;
  logic [CW-1:0] slice_q;
  logic [DW-1:0] phase_q;
  logic          busy_take;

  assign busy_take       = (state_q != BSF_RUN) && sample_valid_in;
  assign sample_take_out = busy_take;
  assign load_out        = busy_take;
  assign ctrl_out.first  = (state_q == BSF_RUN) && (slice_q == '0);
  assign ctrl_out.add_sub = !(slice_q == CW'(SLICES - 1));
  assign ctrl_out.last   = (state_q == BSF_RUN) && (slice_q == CW'(SLICES - 1));
  assign result_keep_out = (phase_q == '0);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= BSF_IDLE;
      slice_q <= '0;
    end else if (clk_en_in) begin
      case (state_q)
        BSF_IDLE, BSF_DONE: begin
          slice_q <= '0;
          state_q <= busy_take ? BSF_RUN : BSF_IDLE;
        end
        BSF_RUN: begin
          // One slice per cycle; wider samples just add slices
          if (slice_q == CW'(SLICES - 1)) begin
            state_q <= BSF_DONE;
            slice_q <= '0;
          end else begin
            slice_q <= slice_q + CW'(1);
          end
        end
        default: state_q <= BSF_IDLE;
      endcase
    end
  end

  // Counts finished computations for simple decimation
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_q <= '0;
    end else if (clk_en_in && ctrl_out.last) begin
      phase_q <= (phase_q == DW'(DECIM - 1)) ? '0 : phase_q + DW'(1);
    end
  end

endmodule : bsf_slice_ctrl

//--- bsf_filter.sv
`timescale 1ns/1ps
// Bit-serial symmetric FIR filter using table arithmetic
module bsf_filter
  import bsf_pkg::*;
#(
  parameter int DATA_W   = DATA_W_DEF,
  parameter int TAPS     = TAPS_DEF,
  parameter int OUT_W    = OUT_W_DEF,
  parameter int COEF_W   = COEF_W_DEF,
  parameter int PAR      = PAR_DEF,
  parameter bit ANTISYM  = 1'b0,
  parameter bit ODD_LEN  = 1'b0,
  parameter int DECIM    = DECIM_DEF,
  parameter bit DECIM2_EFF = 1'b0
) (
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     clk_en_in,
  input  wire logic signed [DATA_W-1:0] filter_input_sample_in,
  input  wire logic                     sample_valid_in,
  output logic                          sample_ready_out,
  output logic signed [OUT_W-1:0]       result_out,
  output logic                          result_valid_out
);

  // Two-chain form: sum width rounded up to even so sums split in pairs
  localparam int SUM_W   = DATA_W + 1;
  localparam int SUM_WP  = (PAR == 2) ? SUM_W + (SUM_W % 2) : SUM_W;
  localparam int SLICES  = SUM_WP / PAR;
  localparam int STAGES  = TAPS - (ODD_LEN ? 1 : 0);
  localparam int PAIRS   = TAPS / 2;
  localparam int SECS    = (PAIRS + PAIRS_PER_SEC - 1) / PAIRS_PER_SEC;
  localparam int PART_W  = COEF_W + 2 + $clog2(SECS + 1);
  localparam int ACC_W   = PART_W + SUM_WP + 1;
  localparam int SHIFT   = (PAR == 2) ? ACC_SHIFT_2 : ACC_SHIFT_1;

  logic signed [DATA_W-1:0] taps_q [STAGES];
  logic signed [SUM_WP-1:0] psum_q [SECS*PAIRS_PER_SEC];
  logic signed [ACC_W-1:0]  acc_q;
  logic signed [OUT_W-1:0]  result_q;
  logic                     valid_q;
  logic                     steer_q;
  logic                     load;
  logic                     take;
  logic                     keep;
  bsf_ctrl_type             ctrl;
  logic signed [PART_W-1:0] chain_sum [PAR];
  logic signed [ACC_W-1:0]  combined;
  logic signed [ACC_W-1:0]  acc_d;
  logic                     shift_en;

  bsf_slice_ctrl #(
    .SLICES (SLICES),
    .DECIM  (DECIM)
  ) u_ctrl (
    .sys_clk_in      (sys_clk_in),
    .rst_in          (rst_in),
    .clk_en_in       (clk_en_in),
    .sample_valid_in (sample_valid_in),
    .sample_take_out (take),
    .load_out        (load),
    .ctrl_out        (ctrl),
    .result_keep_out (keep)
  );

  assign sample_ready_out = take;

  // Toggle steering: only this bit moves at the input rate
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      steer_q <= 1'b0;
    end else if (clk_en_in && take && DECIM2_EFF) begin
      steer_q <= ~steer_q;
    end
  end

  // Efficient decimator advances the even lanes on alternate samples only; odd lanes take the others
  assign shift_en = load && (!DECIM2_EFF || steer_q);

  // Tap delay line; in decimating mode new data skips a stage
  genvar gi;
  generate
    for (gi = 0; gi < STAGES; gi++) begin : g_tap
      // Source stage fixed at elaboration so no index ever falls off the line
      localparam int SRC      = (gi < 2) ? 0 : (DECIM2_EFF ? gi - 2 : gi - 1);
      localparam bit FROM_IN  = (gi == 0) || (DECIM2_EFF && gi == 1);
      localparam bit ODD_LANE = DECIM2_EFF && (gi % 2 == 1);
      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          taps_q[gi] <= '0;
        end else if (clk_en_in && load && (ODD_LANE ? !steer_q : shift_en)) begin
          taps_q[gi] <= FROM_IN ? filter_input_sample_in : taps_q[SRC];
        end
      end
    end
  endgenerate

  // Mirrored taps summed (or subtracted), then shifted out LSB first
  // Sums see the line as it stood before this take, so results lag one sample
  generate
    for (gi = 0; gi < SECS*PAIRS_PER_SEC; gi++) begin : g_pair
      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          psum_q[gi] <= '0;
        end else if (clk_en_in) begin
          if (gi >= PAIRS) begin
            psum_q[gi] <= '0;
          end else if (load) begin
            psum_q[gi] <= ANTISYM
              ? SUM_WP'($signed(taps_q[gi])) - SUM_WP'($signed(taps_q[STAGES-1-gi]))
              : SUM_WP'($signed(taps_q[gi])) + SUM_WP'($signed(taps_q[STAGES-1-gi]));
          end else begin
            psum_q[gi] <= psum_q[gi] >>> PAR;
          end
        end
      end
    end
  endgenerate

  // One table per section per chain, reused for every slice; chains see adjacent bits
  genvar ci, si;
  generate
    for (ci = 0; ci < PAR; ci++) begin : g_chain
      logic signed [COEF_W+1:0] part [SECS];
      for (si = 0; si < SECS; si++) begin : g_sec
        bsf_coef_table #(
          .COEF_W (COEF_W)
        ) u_tab (
          .addr_in ({psum_q[si*4+3][ci], psum_q[si*4+2][ci],
                     psum_q[si*4+1][ci], psum_q[si*4][ci]}),
          .sum_out (part[si])
        );
      end
      always_comb begin
        chain_sum[ci] = '0;
        for (int k = 0; k < SECS; k++) begin
          chain_sum[ci] = chain_sum[ci] + PART_W'(part[k]);
        end
      end
    end
  endgenerate

  // Top chain carries the sign bit on the last slice and is subtracted
  always_comb begin
    combined = '0;
    for (int c = 0; c < PAR; c++) begin
      if (c == PAR - 1 && !ctrl.add_sub) begin
        combined = combined - (ACC_W'(chain_sum[c]) <<< (SUM_WP - PAR + c));
      end else begin
        combined = combined + (ACC_W'(chain_sum[c]) <<< (SUM_WP - PAR + c));
      end
    end
  end

  // Scaling accumulator: halve (or quarter) then add
  always_comb begin
    if (ctrl.first) begin
      acc_d = combined;
    end else begin
      acc_d = (acc_q >>> SHIFT) + combined;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q <= '0;
    end else if (clk_en_in && (ctrl.first || ctrl.add_sub || ctrl.last) && !load) begin
      acc_q <= acc_d;
    end
  end

  // Result register keeps the low OUT_W bits; valid pulses one cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_q <= '0;
      valid_q  <= 1'b0;
    end else if (clk_en_in) begin
      valid_q <= ctrl.last && keep && !load;
      if (ctrl.last && keep && !load) begin
        result_q <= OUT_W'(acc_d);
      end
    end
  end

  assign result_out       = result_q;
  assign result_valid_out = valid_q;

endmodule : bsf_filter

//--- bsf_filter_monitor.sv
// Port checker for the bit-serial table filter
`timescale 1ns/1ps
module bsf_filter_monitor
  import bsf_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int OUT_W  = OUT_W_DEF
) (
  input wire logic                     sys_clk_in,
  input wire logic                     rst_in,
  input wire logic                     clk_en_in,
  input wire logic signed [DATA_W-1:0] filter_input_sample_in,
  input wire logic                     sample_valid_in,
  input wire logic                     sample_ready_out,
  input wire logic signed [OUT_W-1:0]  result_out,
  input wire logic                     result_valid_out
);
  localparam int SL = DATA_W + 1;
  int cnt_q;

  // Enabled cycles since the last take; frozen with the clock enable
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in)
      cnt_q <= 0;
    else if (clk_en_in) begin
      if (sample_ready_out && sample_valid_in)
        cnt_q <= 1;
      else if (cnt_q != 0 && cnt_q <= SL)
        cnt_q <= cnt_q + 1;
      else
        cnt_q <= 0;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_valid_one_cycle: assert property (result_valid_out && clk_en_in |=> !result_valid_out)
    else $error("result valid longer than one cycle");
  a_valid_latency: assert property (result_valid_out |-> cnt_q == SL + 1)
    else $error("result valid at wrong slice count");
  a_result_on_time: assert property (cnt_q == SL + 1 |-> result_valid_out)
    else $error("result missing after last slice");
  a_no_take_busy: assert property (cnt_q inside {[1:SL]} |-> !sample_ready_out)
    else $error("sample taken while running");
  a_ready_needs_offer: assert property (sample_ready_out |-> sample_valid_in)
    else $error("ready without an offered sample");
  a_idle_no_result: assert property (cnt_q == 0 |-> !result_valid_out)
    else $error("result without a take");
  a_result_holds: assert property (!result_valid_out |-> $stable(result_out))
    else $error("result changed without valid");
  a_freeze_state: assert property (!clk_en_in |=> $stable(result_out) && $stable(result_valid_out))
    else $error("state moved while disabled");
endmodule : bsf_filter_monitor

//--- bsf_src_model.sv
// Upstream sample source: offers a held value whenever asked
`timescale 1ns/1ps
module bsf_src_model
  import bsf_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF
) (
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     clk_en_in,
  input  wire logic                     req_in,
  input  wire logic signed [DATA_W-1:0] value_in,
  input  wire logic                     ready_in,
  output logic signed [DATA_W-1:0]      sample_out,
  output logic                          valid_out
);
  logic                     valid_q;
  logic signed [DATA_W-1:0] data_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_q <= 1'b0;
      data_q  <= '0;
    end else if (!valid_q || (ready_in && clk_en_in)) begin
      valid_q <= req_in;
      data_q  <= value_in;
    end
  end

  // Idle bus shows the inverse of the last word, so stale data never looks valid
  assign sample_out = valid_q ? data_q : ~data_q;
  assign valid_out  = valid_q;
endmodule : bsf_src_model

//--- bsf_filter_tb_top.sv
// Self-checking bench for the bit-serial table filter
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module bsf_filter_tb_top;
  import bsf_pkg::*;
  localparam int DW   = 8;
  localparam int OW   = OUT_W_DEF;
  localparam int SL   = DW + 1;
  localparam int TAPS = 8;
  localparam int HSUM = 10; // Sum of the default table weights 1..4
  logic                 sys_clk, rst, en, req, valid, ready, res_valid;
  logic signed [DW-1:0] value, sample;
  logic signed [OW-1:0] result;
  int                   bad_count, checks;

  bsf_filter #(.DATA_W(DW), .TAPS(TAPS)) uut (.sys_clk_in(sys_clk), .rst_in(rst),
    .clk_en_in(en), .filter_input_sample_in(sample), .sample_valid_in(valid),
    .sample_ready_out(ready), .result_out(result), .result_valid_out(res_valid));
  bsf_src_model #(.DATA_W(DW)) src (.sys_clk_in(sys_clk), .rst_in(rst), .clk_en_in(en),
    .req_in(req), .value_in(value), .ready_in(ready), .sample_out(sample), .valid_out(valid));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task wait_result(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (res_valid !== 1'b1 && n < 100);
    `CHK(res_valid, 1'b1)
  endtask : wait_result

  task run_const(input logic signed [DW-1:0] c);
    logic signed [OW-1:0] exp_v;
    int                   n;
    exp_v = OW'(2 * HSUM * int'(c)); // Every mirrored pair sums to 2c
    @(posedge sys_clk);
    value <= c;
    req   <= 1'b1;
    // Two stale offers and one sample of lag pass before the line holds only c
    repeat (TAPS + 3) wait_result(n);
    `CHK(result, exp_v)
    @(posedge sys_clk);
    req <= 1'b0;
  endtask : run_const

  task test_const;
    run_const(8'sh05);
    run_const(8'sh7f);
    run_const(-8'sh80);
    run_const(8'sh00);
    $display("const stream test done");
  endtask : test_const

  task test_freeze;
    int n;
    @(posedge sys_clk);
    value <= 8'sh03;
    req   <= 1'b1;
    do @(negedge sys_clk); while (!(ready && valid));
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    en <= 1'b0;
    repeat (5) @(posedge sys_clk);
    en <= 1'b1;
    wait_result(n);
    `CHK(n + 8, SL + 5)
    $display("clock enable test done");
  endtask : test_freeze

  task test_reset;
    @(posedge sys_clk);
    value <= -8'sh05;
    req   <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1 `CHK(res_valid, 1'b0)
    `CHK(result, {OW{1'b0}})
    @(posedge sys_clk);
    rst <= 1'b0;
    req <= 1'b0;
    run_const(-8'sh05);
    $display("mid-run reset test done");
  endtask : test_reset

  initial begin
    rst       = 1'b1;
    en        = 1'b1;
    req       = 1'b0;
    value     = '0;
    bad_count = 0;
    checks    = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    test_const();
    test_freeze();
    test_reset();
    report_and_stop();
  end

  // Whole run is under 1000 cycles; four times that means a hang
  initial begin
    #(40 * 4000);
    bad_count++;
    $display("[ERR] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule : bsf_filter_tb_top

bind bsf_filter bsf_filter_monitor #(.DATA_W(DATA_W), .OUT_W(OUT_W)) mon (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in),
  .filter_input_sample_in(filter_input_sample_in), .sample_valid_in(sample_valid_in),
  .sample_ready_out(sample_ready_out), .result_out(result_out),
  .result_valid_out(result_valid_out));
